/* File: rtl/isru_link_slave.sv */
// Two-wire serial slave that receives register updates and serves register reads
`include "isru_map.svh"

module isru_link_slave (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    input  wire logic                           scl,
    input  wire logic                           sda_in,
    output logic                                sda_out,
    output logic                                sda_oe,
    input  wire logic [7:0]                     status_in,
    output logic [`ISRU_RW_COUNT*8-1:0]         cfg_regs,
    output logic                                upd_valid,
    input  wire logic                           upd_ready,
    output isru_pkg::isru_upd_type              upd_word,
    output logic                                hs_mode,
    output logic                                busy,
    output logic                                proto_error
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0]                 link_shift;
    logic                       scl_meta;
    logic                       scl_sync;
    logic                       scl_prev;
    logic                       sda_meta;
    logic                       sda_sync;
    logic                       sda_prev;
    logic                       bus_start;
    logic                       bus_stop;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       byte_done;
    logic                       ack_start;
    logic                       ack_sample;
    logic                       ack_end;
    logic [3:0]                 bit_cnt;
    isru_pkg::isru_state_type   state;
    isru_pkg::isru_state_type   after_ack;
    logic                       ack_go;
    logic [2:0]                 reg_ptr;
    logic [7:0]                 data_hold;
    logic                       commit;
    logic [7:0]                 tx_shift;
    logic [7:0]                 rd_data;
    isru_pkg::isru_upd_type     spare;
    logic                       spare_valid;
    logic                       buf_ready;
    logic                       pop;
    isru_pkg::isru_upd_type     push_word;

    // ------------------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------------------
    // bits shift in on each clock rise
    // Only data lives here; framing is decided on the system clock, which
    // sees the bus conditions that this clock cannot, since the clock
    // stands still between frames. The shifter is read only after a
    // synchronised rise, when it is stable for the rest of the clock period.
    always_ff @(posedge scl) begin
        link_shift <= {link_shift[6:0], sda_in};
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // oversampling covers every bus rate
    // At 200 MHz the shortest high phase of the fastest rate still spans
    // about a dozen cycles, so three-cycle latency is harmless.
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_meta <= `ISRU_LINE_IDLE;
            scl_sync <= `ISRU_LINE_IDLE;
            scl_prev <= `ISRU_LINE_IDLE;
            sda_meta <= `ISRU_LINE_IDLE;
            sda_sync <= `ISRU_LINE_IDLE;
            sda_prev <= `ISRU_LINE_IDLE;
        end else if (ce) begin
            scl_meta <= scl;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    // ------------------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------------------
    // start is a data fall while clock high
    assign bus_start  = scl_sync && scl_prev && sda_prev && !sda_sync;
    // stop is a data rise while clock high
    assign bus_stop   = scl_sync && scl_prev && !sda_prev && sda_sync;
    assign scl_rise   = scl_sync && !scl_prev;
    assign scl_fall   = !scl_sync && scl_prev;
    assign byte_done  = scl_rise && bit_cnt == `ISRU_CNT_LAST_BIT;
    assign ack_start  = scl_fall && bit_cnt == `ISRU_CNT_ACK;
    assign ack_sample = scl_rise && bit_cnt == `ISRU_CNT_ACK;
    assign ack_end    = scl_fall && bit_cnt == `ISRU_CNT_ACK_END;

    // ------------------------------------------------------------------------
    // Bit counter: rises seen within the current nine-bit frame
    // ------------------------------------------------------------------------
    // eight bits and one acknowledge per frame
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt <= `ISRU_CNT_ZERO;
        end else if (ce) begin
            if (bus_start || bus_stop || ack_end) begin
                bit_cnt <= `ISRU_CNT_ZERO;
            end else if (scl_rise && bit_cnt != `ISRU_CNT_ACK_END) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Byte-level state machine
    // ------------------------------------------------------------------------
    // Each byte is judged at its eighth rise; the verdict (acknowledge and
    // next state) is held until the acknowledge bit ends.
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= isru_pkg::ST_IDLE;
            after_ack <= isru_pkg::ST_IDLE;
            ack_go    <= 1'b0;
            reg_ptr   <= `ISRU_RO_INDEX;
            data_hold <= `ISRU_RW_RESET;
        end else if (ce) begin
            if (bus_stop) begin
                state  <= isru_pkg::ST_IDLE;
                ack_go <= 1'b0;
            end else if (bus_start) begin
                // start or repeated start reopens addressing
                state  <= isru_pkg::ST_ADDR;
                ack_go <= 1'b0;
            end else if (byte_done) begin
                unique case (state)
                    isru_pkg::ST_ADDR: begin
                        if (isru_pkg::isru_is_hs_code(link_shift)) begin
                            ack_go    <= 1'b0;
                            after_ack <= isru_pkg::ST_IDLE;
                        end else if (isru_pkg::isru_addr_match(link_shift)) begin
                            ack_go    <= 1'b1;
                            // direction bit picks read or write
                            if (link_shift[`ISRU_DIR_POS] == `ISRU_DIR_READ) begin
                                after_ack <= isru_pkg::ST_READ;
                            end else begin
                                after_ack <= isru_pkg::ST_REG;
                            end
                        end else begin
                            ack_go    <= 1'b0;
                            after_ack <= isru_pkg::ST_IDLE;
                        end
                    end
                    isru_pkg::ST_REG: begin
                        if (isru_pkg::isru_upper_clear(link_shift)) begin
                            ack_go    <= 1'b1;
                            reg_ptr   <= link_shift[`ISRU_SEL_MSB:0];
                            after_ack <= isru_pkg::ST_DATA;
                        end else begin
                            ack_go    <= 1'b0;
                            after_ack <= isru_pkg::ST_IDLE;
                        end
                    end
                    isru_pkg::ST_DATA: begin
                        // data byte acknowledged when it can be kept
                        // A full buffer refuses the byte rather than drop it.
                        ack_go    <= buf_ready;
                        data_hold <= link_shift;
                        // further register and data pairs may follow
                        after_ack <= buf_ready ? isru_pkg::ST_REG : isru_pkg::ST_IDLE;
                    end
                    isru_pkg::ST_READ: begin
                        ack_go    <= 1'b0;
                        after_ack <= isru_pkg::ST_READ;
                    end
                    isru_pkg::ST_IDLE: begin
                        ack_go    <= 1'b0;
                        after_ack <= isru_pkg::ST_IDLE;
                    end
                endcase
            end else if (ack_sample && state == isru_pkg::ST_READ && sda_sync) begin
                // Master declined further read data
                after_ack <= isru_pkg::ST_IDLE;
            end else if (ack_end) begin
                state <= after_ack;
            end
        end
    end

    // commit on the falling edge ending the acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            commit <= 1'b0;
        end else if (ce) begin
            commit <= ack_end && ack_go && state == isru_pkg::ST_DATA && !bus_start && !bus_stop;
        end
    end

    // ------------------------------------------------------------------------
    // Data line driver (open drain: enable high pulls the line low)
    // ------------------------------------------------------------------------
    // the line only changes after a clock fall
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_oe   <= 1'b0;
            sda_out  <= 1'b0;
            tx_shift <= `ISRU_SHIFT_RESET;
        end else if (ce) begin
            sda_out <= 1'b0;
            if (bus_start || bus_stop) begin
                sda_oe <= 1'b0;
            end else if (ack_start) begin
                // hold low through the ninth high phase
                sda_oe <= ack_go && state != isru_pkg::ST_READ;
            end else if (ack_end) begin
                if (after_ack == isru_pkg::ST_READ) begin
                    sda_oe   <= !rd_data[`ISRU_BYTE_MSB];
                    tx_shift <= {rd_data[6:0], 1'b1};
                end else begin
                    sda_oe <= 1'b0;
                end
            end else if (scl_fall && state == isru_pkg::ST_READ &&
                         bit_cnt != `ISRU_CNT_ZERO) begin
                sda_oe   <= !tx_shift[`ISRU_BYTE_MSB];
                tx_shift <= {tx_shift[6:0], 1'b1};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Speed mode flag
    // ------------------------------------------------------------------------
    // Nothing here depends on it; the flag is
    // exported so the pad can switch its filters and slew control.
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_mode <= 1'b0;
        end else if (ce) begin
            if (bus_stop) begin
                hs_mode <= 1'b0;
            end else if (byte_done && state == isru_pkg::ST_ADDR &&
                         isru_pkg::isru_is_hs_code(link_shift)) begin
                // speed holds across the repeated start
                hs_mode <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Two-entry update buffer
    // ------------------------------------------------------------------------
    // The head is the output register; the spare absorbs one update while
    // the consumer stalls. Filling side ready is the empty spare.
    assign buf_ready = !spare_valid;
    assign pop       = upd_valid && upd_ready;
    assign push_word = '{sel: reg_ptr, data: data_hold};

    always_ff @(posedge clk) begin
        if (rst) begin
            upd_valid   <= 1'b0;
            upd_word    <= '0;
            spare       <= '0;
            spare_valid <= 1'b0;
        end else if (ce) begin
            if (spare_valid) begin
                if (pop) begin
                    upd_word    <= spare;
                    spare_valid <= 1'b0;
                end
            end else if (pop || !upd_valid) begin
                upd_valid <= commit;
                if (commit) begin
                    upd_word <= push_word;
                end
            end else if (commit) begin
                spare       <= push_word;
                spare_valid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register store, written as updates leave the buffer
    // ------------------------------------------------------------------------
    // four writable and one read-only register
    isru_reg_mem u_regs (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .wr_en    (pop),
        .wr_word  (upd_word),
        .rd_sel   (reg_ptr),
        .ro_value (status_in),
        .rd_data  (rd_data),
        .rw_regs  (cfg_regs)
    );

    // ------------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------------
    // Busy while addressed; error sticks until the next start so software
    // on the charger side can see a refused byte after the frame ends.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy        <= 1'b0;
            proto_error <= 1'b0;
        end else if (ce) begin
            busy <= state != isru_pkg::ST_IDLE && state != isru_pkg::ST_ADDR;
            if (byte_done && ((state == isru_pkg::ST_REG &&
                               !isru_pkg::isru_upper_clear(link_shift)) ||
                              (state == isru_pkg::ST_DATA && !buf_ready))) begin
                proto_error <= 1'b1;
            end else if (bus_start) begin
                proto_error <= 1'b0;
            end
        end
    end

endmodule

/* File: rtl/isru_map.svh */
// Constants of the serial register-update slave: address, codes, counts and reset values
`ifndef ISRU_MAP_SVH
`define ISRU_MAP_SVH

// ----------------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------------
`define ISRU_SLAVE_ADDR     7'h6B
`define ISRU_DIR_READ       1'b1
`define ISRU_HS_PREFIX      5'h01
`define ISRU_UPPER_ZERO     5'h00

// ----------------------------------------------------------------------------
// Byte field positions
// ----------------------------------------------------------------------------
`define ISRU_BYTE_MSB       7
`define ISRU_ADDR_LSB       1
`define ISRU_DIR_POS        0
`define ISRU_UPPER_LSB      3
`define ISRU_SEL_MSB        2

// ----------------------------------------------------------------------------
// Register file
// ----------------------------------------------------------------------------
`define ISRU_REG_COUNT      3'h5
`define ISRU_RO_INDEX       3'h0
`define ISRU_RW_FIRST       3'h1
`define ISRU_RW_COUNT       4
`define ISRU_RW_RESET       8'h00
`define ISRU_UNMAPPED_DATA  8'hFF

// ----------------------------------------------------------------------------
// Bit counter marks within one nine-bit frame and line levels
// ----------------------------------------------------------------------------
`define ISRU_CNT_ZERO       4'h0
`define ISRU_CNT_LAST_BIT   4'h7
`define ISRU_CNT_ACK        4'h8
`define ISRU_CNT_ACK_END    4'h9
`define ISRU_LINE_IDLE      1'b1
`define ISRU_SHIFT_RESET    8'hFF

`endif

/* File: rtl/isru_pkg.sv */
// Types and byte decoders shared by the register-update slave files
`include "isru_map.svh"

package isru_pkg;

    // ------------------------------------------------------------------------
    // Byte-level protocol states
    // ------------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_REG  = 5'h04,
        ST_DATA = 5'h08,
        ST_READ = 5'h10
    } isru_state_type;

    // One register update: target select and data byte
    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] data;
    } isru_upd_type;

    // ------------------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------------------
    function automatic logic isru_sel_valid(input logic [2:0] sel);
        return sel < `ISRU_REG_COUNT;
    endfunction

    function automatic logic isru_is_hs_code(input logic [7:0] b);
        return b[`ISRU_BYTE_MSB:`ISRU_UPPER_LSB] == `ISRU_HS_PREFIX;
    endfunction

    function automatic logic isru_addr_match(input logic [7:0] b);
        return b[`ISRU_BYTE_MSB:`ISRU_ADDR_LSB] == `ISRU_SLAVE_ADDR;
    endfunction

    function automatic logic isru_upper_clear(input logic [7:0] b);
        return b[`ISRU_BYTE_MSB:`ISRU_UPPER_LSB] == `ISRU_UPPER_ZERO;
    endfunction

endpackage

/* File: rtl/isru_reg_mem.sv */
// Five-entry register store: four writable registers, one read-only, registered read
`include "isru_map.svh"

module isru_reg_mem (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               ce,
    input  wire logic                               wr_en,
    input  wire isru_pkg::isru_upd_type             wr_word,
    input  wire logic [2:0]                         rd_sel,
    input  wire logic [7:0]                         ro_value,
    output logic [7:0]                              rd_data,
    output logic [`ISRU_RW_COUNT*8-1:0]             rw_regs
);

    logic [7:0]                     store [`ISRU_RW_COUNT]; // Unpacked: one owner per entry
    logic [2:0]                     rd_index;

    // ------------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `ISRU_RW_COUNT; i = i + 1) begin : g_rw
            // Writes to the read-only slot or to unmapped selects match no entry
            always_ff @(posedge clk) begin
                if (rst) begin
                    store[i] <= `ISRU_RW_RESET;
                end else if (ce && wr_en && wr_word.sel == 3'(i + 1)) begin
                    store[i] <= wr_word.data;
                end
            end
            assign rw_regs[i*8 +: 8] = store[i];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------------------
    assign rd_index = 3'(rd_sel - `ISRU_RW_FIRST);

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= `ISRU_UNMAPPED_DATA;
        end else if (ce) begin
            if (!isru_pkg::isru_sel_valid(rd_sel)) begin
                rd_data <= `ISRU_UNMAPPED_DATA;
            end else if (rd_sel == `ISRU_RO_INDEX) begin
                rd_data <= ro_value;
            end else begin
                rd_data <= store[rd_index[1:0]];
            end
        end
    end

endmodule

/* File: test/isru_bus_master.sv */
// Bus master model: makes the link clock and pulls the data line low
module isru_bus_master (
    output logic     scl,
    output logic     sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 40; // Quarter of the 160 ns link period
    // Idle bus: clock parked high, data left to its pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    // byte then acknowledge; ninth bit released, so reads end unacknowledged
    task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(1'b1, a);
        ack = !a;
    endtask
    // read byte acknowledged by the master, so the slave sends again
    task automatic xfer_more(output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r[i]);
        end
        bit_io(1'b0, a);
    endtask
    // start, also used as repeated start
    task automatic start();
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #(2*Q) sda_pull = 1'b1;
        #(2*Q) scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #(2*Q) sda_pull = 1'b0;
        #(4*Q);
    endtask
endmodule

/* File: test/isru_link_monitor.sv */
// Port checker of the register-update slave
module isru_link_monitor (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire logic                  scl,
    input wire logic                  sda_in,
    input wire logic                  sda_out,
    input wire logic                  sda_oe,
    input wire logic [31:0]           cfg_regs,
    input wire logic                  upd_valid,
    input wire logic                  upd_ready,
    input wire isru_pkg::isru_upd_type upd_word,
    input wire logic                  hs_mode,
    input wire logic                  busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Pop of a word aimed at a writable register
    wire logic take = upd_valid && upd_ready && ce && upd_word.sel inside {[3'h1:3'h4]};
    sda_out_low_a: assert property (sda_out == 1'b0) else $error("sda_out high");
    oe_rise_a: assert property ($rose(sda_oe) |-> !scl) else $error("oe rose, scl high");
    oe_steady_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("oe moved while scl high");
    reset_quiet_a: assert property ($fell(rst) |-> !sda_oe && !upd_valid && !busy
        && !hs_mode && cfg_regs == 32'h0) else $error("state after reset");
    upd_hold_a: assert property (upd_valid && !upd_ready |=> upd_valid
        && $stable(upd_word)) else $error("update word lost");
    cfg_commit_a: assert property (take |=> cfg_regs[($past(upd_word.sel) - 3'h1)*8 +: 8]
        == $past(upd_word.data)) else $error("commit missing");
    cfg_keep_a: assert property (!take |=> $stable(cfg_regs)) else $error("stray write");
    stop_idle_a: assert property (scl && $past(scl) && $rose(sda_in)
        |-> ##[1:10] (!busy && !sda_oe)) else $error("busy after stop");
    hs_stop_a: assert property (scl && $past(scl) && $rose(sda_in)
        |-> ##[1:10] !hs_mode) else $error("high speed after stop");
endmodule

bind isru_link_slave isru_link_monitor i_isru_link_monitor (
    .clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .cfg_regs(cfg_regs), .upd_valid(upd_valid), .upd_ready(upd_ready),
    .upd_word(upd_word), .hs_mode(hs_mode), .busy(busy)
);

/* File: test/tb.sv */
// Self-checking bench of the register-update slave under random bus traffic
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        upd_ready = 1'b0;
    logic        hold = 1'b0;
    logic        scl, sda_pull, sda_oe, hs, perr, ack;
    logic [7:0]  status = 8'h00;
    logic [7:0]  rd, s;
    logic [7:0]  exp_reg [8] = '{default: 8'h00};
    logic [31:0] seed = 32'h0CB07016;
    logic [31:0] cfg_regs;
    int          failures = 0;
    int          tests_run = 0;
    // Open-drain data line with pull-up
    wire logic   sda = !(sda_pull || sda_oe === 1'b1);
    isru_link_slave i_isru_link_slave (.clk(clk), .rst(rst), .ce(1'b1), .scl(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .status_in(status), .cfg_regs(cfg_regs),
        .upd_valid(), .upd_ready(upd_ready), .upd_word(), .hs_mode(hs), .busy(),
        .proto_error(perr));
    isru_bus_master i_isru_bus_master (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    always #2.5 clk = !clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Random consumer stalls; hold forces a full buffer
    always @(posedge clk) begin
        #1;
        seed = lfsr(seed);
        upd_ready = !hold && seed[0];
    end
    function automatic logic [31:0] exp_cfg();
        return {exp_reg[4], exp_reg[3], exp_reg[2], exp_reg[1]};
    endfunction
    function automatic logic [7:0] exp_read(input logic [2:0] r);
        return (r == 3'h0) ? status : (r < 3'h5) ? exp_reg[r] : 8'hFF;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic sel_addr(input logic [7:0] a, input logic e);
        i_isru_bus_master.start();
        i_isru_bus_master.xfer(a, rd, ack);
        chk(ack, e);
    endtask
    // Register byte then data byte; mirror only acknowledged writable targets
    task automatic wr(input logic [7:0] r, input logic [7:0] d, input logic ea, input logic ed);
        i_isru_bus_master.xfer(r, rd, ack);
        chk(ack, ea);
        if (ack) begin
            i_isru_bus_master.xfer(d, rd, ack);
            chk(ack, ed);
            if (ack && r[2:0] inside {[3'h1:3'h4]}) exp_reg[r[2:0]] = d;
        end
    endtask
    // Bounded wait for the mirror; running out ends the run as a failure
    task automatic wait_cfg();
        for (int n = 0; n < 400 && cfg_regs !== exp_cfg(); n++) begin
            @(posedge clk);
            #1;
        end
        chk(cfg_regs, exp_cfg());
        if (cfg_regs !== exp_cfg()) begin
            report_and_stop();
        end
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        #1; // Bus events keep off the sampling edge
        for (int k = 0; k < 8; k++) begin
            status = seed[31:24];
            sel_addr({7'h6B ^ {seed[6:1], 1'b1}, 1'b0}, 1'b0);
            i_isru_bus_master.stop();
            if (k[0]) begin
                sel_addr({5'h01, seed[2:0]}, 1'b0);
            end
            sel_addr(8'hD6, 1'b1);
            chk(hs, k[0]);
            wr({5'h00, seed[2:0]}, seed[15:8], 1'b1, 1'b1);
            wr({5'h00, seed[5:3]}, seed[23:16], 1'b1, 1'b1);
            wr({seed[7:3] | 5'h10, seed[2:0]}, 8'h00, 1'b0, 1'b0);
            chk(perr, 1'b1);
            i_isru_bus_master.stop();
            chk(hs, 1'b0);
            wait_cfg();
            s = {5'h00, seed[2:0]};
            sel_addr(8'hD6, 1'b1);
            i_isru_bus_master.xfer(s, rd, ack);
            sel_addr(8'hD7, 1'b1);
            i_isru_bus_master.xfer_more(rd);
            chk(rd, exp_read(s[2:0]));
            i_isru_bus_master.xfer(8'hFF, rd, ack);
            chk(rd, exp_read(s[2:0]));
            i_isru_bus_master.stop();
        end
        hold = 1'b1;
        sel_addr(8'hD6, 1'b1);
        for (int j = 1; j < 4; j++) begin
            wr(j[7:0], seed[7:0], 1'b1, j < 3);
        end
        chk(perr, 1'b1);
        hold = 1'b0;
        i_isru_bus_master.stop();
        wait_cfg();
        report_and_stop();
    end
endmodule
